// ### rtl/tlv_cfg_pkg.sv
// Constants shared by the configuration decoder and its register map
package tlv_cfg_pkg;
    // Clock and shaping window
    localparam int          CLK_HZ         = 25_000_000;
    localparam int          RATE_WINDOW_MS = 1000;
    localparam int          RATE_WINDOW_CYC = CLK_HZ / 1000 * RATE_WINDOW_MS;

    // Top-level setting types and value lengths
    localparam logic [7:0]  T_DS_FREQ     = 8'h01;
    localparam logic [7:0]  T_US_CHAN     = 8'h02;
    localparam logic [7:0]  T_NET_ACCESS  = 8'h03;
    localparam logic [7:0]  T_SVC_CLASS   = 8'h04;
    localparam logic [7:0]  L_DS_FREQ     = 8'h04;
    localparam logic [7:0]  L_US_CHAN     = 8'h01;
    localparam logic [7:0]  L_NET_ACCESS  = 8'h01;

    // Service class sub-types and value lengths
    localparam logic [7:0]  S_CLASS_ID    = 8'h01;
    localparam logic [7:0]  S_DS_RATE     = 8'h02;
    localparam logic [7:0]  S_US_RATE     = 8'h03;
    localparam logic [7:0]  S_PRIORITY    = 8'h04;
    localparam logic [7:0]  S_MIN_RATE    = 8'h05;
    localparam logic [7:0]  S_BURST       = 8'h06;
    localparam logic [7:0]  class_privacy_enable_subtype = 8'h07;
    localparam logic [7:0]  L_ONE         = 8'h01;
    localparam logic [7:0]  L_TWO         = 8'h02;
    localparam logic [7:0]  L_FOUR        = 8'h04;

    // Value ranges
    localparam logic [31:0] FREQ_STEP_HZ  = 32'hf424;
    localparam logic [31:0] CLASS_ID_MIN  = 32'h1;
    localparam logic [31:0] CLASS_ID_MAX  = 32'h10;
    localparam logic [31:0] PRIORITY_MAX  = 32'h7;
    localparam logic [31:0] FLAG_MAX      = 32'h1;

    // Register offsets
    localparam logic [7:0]  R_CTRL        = 8'h00;
    localparam logic [7:0]  R_STATUS      = 8'h04;
    localparam logic [7:0]  R_DS_FREQ     = 8'h08;
    localparam logic [7:0]  R_US_CHAN     = 8'h0c;
    localparam logic [7:0]  R_CLASS       = 8'h10;
    localparam logic [7:0]  R_DS_RATE     = 8'h14;
    localparam logic [7:0]  R_US_RATE     = 8'h18;
    localparam logic [7:0]  R_MIN_RATE    = 8'h1c;
    localparam logic [7:0]  R_BURST       = 8'h20;

    // Field positions and reset values
    localparam int          CTRL_SHAPE    = 0;
    localparam int          ST_ERROR      = 0;
    localparam int          ST_LEGACY     = 1;
    localparam int          ST_UCD_WAIT   = 2;
    localparam int          ST_ACCESS     = 3;
    localparam int          ST_FREQ_SET   = 4;
    localparam logic        CTRL_RESET    = 1'b1;
    localparam logic        ACCESS_RESET  = 1'b1;
endpackage : tlv_cfg_pkg

// ### rtl/modem_config_tlv_rate_shaper.sv
// Configuration setting decoder, access gate and upstream rate shaper
`timescale 1ns/1ns
// Overview of operation
// RQ1: Type 1, four octets, sets downstream frequency
// RQ2: Frequency not multiple of 62500 is invalid
// RQ3: Type 2, one octet, sets upstream channel
// RQ4: Hold upstream until matching channel descriptor arrives
// RQ5: Access 0 blocks CPE traffic, not own
// RQ6: Own management traffic passes with access off
// RQ7: Headend allocates flows ignoring access value
// RQ8: Class setting present selects legacy mode
// RQ9: Sub-types decoded only inside class setting
// RQ10: Class identifier valid only 1 to 16
// RQ11: Headend caps downstream unicast per second
// RQ12: Headend sums downstream rates across identifiers
// RQ13: Upstream bytes limited per one-second window
// RQ14: Over-rate frames are held, not dropped
// RQ15: Headend polices upstream rate and alarms
// RQ16: Sub-type 3 is four-octet upstream rate
// RQ17: Priority valid 0 to 7 only
// RQ18: Burst zero unlimited, else byte cap
// RQ19: Headend guarantees minimum upstream rate
// RQ20: Sub-type 7 one octet privacy enable
// RQ21: Fixed value lengths per class sub-type
// RQ22: Multi-octet values arrive most significant first
// RQ23: Unknown types skipped by their length
// RQ24: Range or length fault sets error flag
module modem_config_tlv_rate_shaper #(
    parameter int WINDOW_CYC = tlv_cfg_pkg::RATE_WINDOW_CYC
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        cfg_start,
    input  wire logic        cfg_valid,
    input  wire logic [7:0]  cfg_byte,
    input  wire logic        ucd_valid,
    input  wire logic [7:0]  ucd_chan_id,
    input  wire logic        tx_req,
    input  wire logic [15:0] tx_len,
    input  wire logic        tx_from_cpe,
    input  wire logic        tx_mgmt,
    output logic             tx_grant,
    output logic             tx_block,
    output logic [31:0]      ds_freq,
    output logic             ds_freq_set,
    output logic             class_done,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata
);
    typedef enum logic [1:0] {P_TYPE, P_LEN, P_VAL} parse_e;

    parse_e      state;
    logic        inner;
    logic [7:0]  typ;
    logic [7:0]  len;
    logic [7:0]  rem;
    logic [7:0]  outer;
    logic [23:0] acc;
    logic [7:0]  us_chan;
    logic        network_access_gate;
    logic        legacy;
    logic        ucd_wait;
    logic        cfg_error;
    logic        shape_on;
    logic [7:0]  class_id;
    logic [2:0]  priority_lvl;
    logic        privacy;
    logic [31:0] ds_rate;
    logic [31:0] us_rate;
    logic [31:0] min_rate;
    logic [15:0] burst;
    logic [31:0] win_cnt;
    logic [31:0] used_bytes;

    // Expected value length, zero for the top-level class setting and for a type this block does not decode
    function automatic logic [7:0] exp_len(input logic in_class,
                                           input logic [7:0] t);
        logic [7:0] r;
        r = 8'h00;
        if (in_class) begin
            case (t)
                tlv_cfg_pkg::S_CLASS_ID: r = tlv_cfg_pkg::L_ONE;
                tlv_cfg_pkg::S_DS_RATE:  r = tlv_cfg_pkg::L_FOUR;
                tlv_cfg_pkg::S_US_RATE:  r = tlv_cfg_pkg::L_FOUR;
                tlv_cfg_pkg::S_PRIORITY: r = tlv_cfg_pkg::L_ONE;
                tlv_cfg_pkg::S_MIN_RATE: r = tlv_cfg_pkg::L_FOUR;
                tlv_cfg_pkg::S_BURST:    r = tlv_cfg_pkg::L_TWO;
                tlv_cfg_pkg::class_privacy_enable_subtype:
                                         r = tlv_cfg_pkg::L_ONE;
                default:                 r = 8'h00;
            endcase
        end else begin
            case (t)
                tlv_cfg_pkg::T_DS_FREQ:    r = tlv_cfg_pkg::L_DS_FREQ;
                tlv_cfg_pkg::T_US_CHAN:    r = tlv_cfg_pkg::L_US_CHAN;
                tlv_cfg_pkg::T_NET_ACCESS: r = tlv_cfg_pkg::L_NET_ACCESS;
                default:                   r = 8'h00;
            endcase
        end
        return r;
    endfunction : exp_len

    // Byte decode
    wire         take      = cfg_valid && !cfg_start;
    wire [7:0]   want_len  = exp_len(inner, typ);
    wire         known     = want_len != 8'h00;
    wire         last_val  = take && state == P_VAL && rem == 8'h01;
    wire [31:0]  val_word  = {acc, cfg_byte}; // see RQ22
    wire         commit    = last_val && known && len == want_len;
    wire         open_cls  = take && state == P_LEN && !inner &&
                             typ == tlv_cfg_pkg::T_SVC_CLASS;
    wire         len_bad   = take && state == P_LEN && !open_cls &&
                             want_len != 8'h00 && cfg_byte != want_len;
    wire         cls_end   = take && inner && outer == 8'h01;
    // A sub-setting that spills past its class is a length fault
    wire         cls_trunc = cls_end && !(state == P_VAL && rem == 8'h01) &&
                             !(state == P_LEN && cfg_byte == 8'h00);
    wire [7:0]   next_rem  = rem - 8'h01;
    wire [7:0]   next_outer = outer - 8'h01;

    // Commit targets and range checks
    wire c_freq  = commit && !inner && typ == tlv_cfg_pkg::T_DS_FREQ;
    wire c_chan  = commit && !inner && typ == tlv_cfg_pkg::T_US_CHAN;
    wire c_acc   = commit && !inner && typ == tlv_cfg_pkg::T_NET_ACCESS;
    wire c_cid   = commit && inner && typ == tlv_cfg_pkg::S_CLASS_ID;
    wire c_dsr   = commit && inner && typ == tlv_cfg_pkg::S_DS_RATE;
    wire c_usr   = commit && inner && typ == tlv_cfg_pkg::S_US_RATE;
    wire c_pri   = commit && inner && typ == tlv_cfg_pkg::S_PRIORITY;
    wire c_min   = commit && inner && typ == tlv_cfg_pkg::S_MIN_RATE;
    wire c_bst   = commit && inner && typ == tlv_cfg_pkg::S_BURST;
    wire c_prv   = commit && inner &&
                   typ == tlv_cfg_pkg::class_privacy_enable_subtype;
    // Constant modulus, folds to a fixed divider network
    wire freq_ok = (val_word % tlv_cfg_pkg::FREQ_STEP_HZ) == 32'h0;
    wire cid_ok  = val_word >= tlv_cfg_pkg::CLASS_ID_MIN &&
                   val_word <= tlv_cfg_pkg::CLASS_ID_MAX;
    wire pri_ok  = val_word <= tlv_cfg_pkg::PRIORITY_MAX;
    wire flag_ok = val_word <= tlv_cfg_pkg::FLAG_MAX;
    wire range_bad = (c_freq && !freq_ok) || (c_cid && !cid_ok) ||
                     (c_pri && !pri_ok) ||
                     ((c_acc || c_prv) && !flag_ok);
    wire err_set = len_bad || cls_trunc || range_bad; // see RQ24

    // Register bus decode
    wire wr_ctrl = wr && addr == tlv_cfg_pkg::R_CTRL;
    wire wr_stat = wr && addr == tlv_cfg_pkg::R_STATUS;
    wire err_clr = wr_stat && wdata[tlv_cfg_pkg::ST_ERROR];

    // Parser sequencing
    always_ff @(posedge mclk) begin
        if (reset || (cfg_valid && cfg_start)) begin
            state <= P_TYPE;
            inner <= 1'b0;
            typ   <= 8'h00;
            len   <= 8'h00;
            rem   <= 8'h00;
            outer <= 8'h00;
            acc   <= 24'h0;
        end else if (take) begin
            if (inner) begin
                outer <= next_outer;
            end
            case (state)
                P_TYPE: begin
                    typ   <= cfg_byte;
                    state <= P_LEN;
                end
                P_LEN: begin
                    len <= cfg_byte;
                    rem <= cfg_byte;
                    acc <= 24'h0;
                    if (open_cls) begin
                        // Sub-types are only meaningful in here
                        outer <= cfg_byte; // see RQ9
                        inner <= cfg_byte != 8'h00;
                        state <= P_TYPE;
                    end else begin
                        // Unknown types fall through here and are skipped
                        state <= cfg_byte == 8'h00 ? P_TYPE
                                                   : P_VAL; // see RQ23
                    end
                end
                P_VAL: begin
                    acc <= val_word[23:0]; // see RQ22
                    rem <= next_rem;
                    if (rem == 8'h01) begin
                        state <= P_TYPE;
                    end
                end
                default: state <= P_TYPE;
            endcase
            if (cls_end) begin
                inner <= 1'b0;
                state <= P_TYPE;
            end
        end
    end

    // Decoded top-level settings
    always_ff @(posedge mclk) begin
        if (reset) begin
            ds_freq             <= 32'h0;
            ds_freq_set         <= 1'b0;
            us_chan             <= 8'h00;
            ucd_wait            <= 1'b0;
            network_access_gate <= tlv_cfg_pkg::ACCESS_RESET;
            legacy              <= 1'b0;
        end else begin
            if (c_freq && freq_ok) begin
                ds_freq     <= val_word; // see RQ1, RQ2
                ds_freq_set <= 1'b1;
            end
            if (c_chan) begin
                us_chan  <= val_word[7:0]; // see RQ3
                ucd_wait <= 1'b1;
            end else if (ucd_valid && ucd_chan_id == us_chan) begin
                ucd_wait <= 1'b0; // see RQ4
            end
            if (c_acc && flag_ok) begin
                network_access_gate <= val_word[0];
            end
            if (open_cls) begin
                legacy <= 1'b1; // see RQ8
            end
        end
    end

    // Service class fields
    always_ff @(posedge mclk) begin
        if (reset) begin
            class_id     <= 8'h00;
            ds_rate      <= 32'h0;
            us_rate      <= 32'h0;
            priority_lvl <= 3'h0;
            min_rate     <= 32'h0;
            burst        <= 16'h0;
            privacy      <= 1'b0;
            class_done   <= 1'b0;
        end else begin
            class_done <= cls_end;
            if (c_cid && cid_ok) begin
                class_id <= val_word[7:0]; // see RQ10
            end
            if (c_dsr) begin
                ds_rate <= val_word; // see RQ21
            end
            if (c_usr) begin
                us_rate <= val_word; // see RQ16
            end
            if (c_pri && pri_ok) begin
                priority_lvl <= val_word[2:0]; // see RQ17
            end
            if (c_min) begin
                min_rate <= val_word;
            end
            if (c_bst) begin
                burst <= val_word[15:0]; // see RQ21
            end
            if (c_prv && flag_ok) begin
                privacy <= val_word[0]; // see RQ20
            end
        end
    end

    // Access gate: own traffic and management always pass
    assign tx_block = tx_req && tx_from_cpe && !tx_mgmt &&
                      !network_access_gate; // see RQ5, RQ6

    // Shaper: a frame waits, never drops, until it fits the window budget
    wire [31:0] byte_cap  = {3'b000, us_rate[31:3]};
    wire [31:0] want_used = used_bytes + {16'h0, tx_len};
    wire        rate_ok   = us_rate == 32'h0 || want_used <= byte_cap;
    wire        burst_ok  = burst == 16'h0 || tx_len <= burst; // see RQ18
    wire        win_end   = win_cnt == WINDOW_CYC - 1;
    assign tx_grant = tx_req && !tx_block && !ucd_wait && burst_ok &&
                      (!shape_on || rate_ok); // see RQ4, RQ13, RQ14

    always_ff @(posedge mclk) begin
        if (reset || win_end) begin
            win_cnt    <= 32'h0;
            used_bytes <= 32'h0; // see RQ13
        end else begin
            win_cnt <= win_cnt + 32'h1;
            if (tx_grant) begin
                used_bytes <= want_used;
            end
        end
    end

    // Control and sticky error; a fault in the clear cycle still sets
    always_ff @(posedge mclk) begin
        if (reset) begin
            shape_on  <= tlv_cfg_pkg::CTRL_RESET;
            cfg_error <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                shape_on <= wdata[tlv_cfg_pkg::CTRL_SHAPE];
            end
            cfg_error <= (cfg_error && !err_clr) || err_set; // see RQ24
        end
    end

    // Register read
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        case (addr)
            tlv_cfg_pkg::R_CTRL:
                rd_mux[tlv_cfg_pkg::CTRL_SHAPE] = shape_on;
            tlv_cfg_pkg::R_STATUS: begin
                rd_mux[tlv_cfg_pkg::ST_ERROR]    = cfg_error;
                rd_mux[tlv_cfg_pkg::ST_LEGACY]   = legacy;
                rd_mux[tlv_cfg_pkg::ST_UCD_WAIT] = ucd_wait;
                rd_mux[tlv_cfg_pkg::ST_ACCESS]   = network_access_gate;
                rd_mux[tlv_cfg_pkg::ST_FREQ_SET] = ds_freq_set;
            end
            tlv_cfg_pkg::R_DS_FREQ:  rd_mux = ds_freq;
            tlv_cfg_pkg::R_US_CHAN:  rd_mux = {24'h0, us_chan};
            tlv_cfg_pkg::R_CLASS:
                rd_mux = {20'h0, privacy, priority_lvl, class_id};
            tlv_cfg_pkg::R_DS_RATE:  rd_mux = ds_rate;
            tlv_cfg_pkg::R_US_RATE:  rd_mux = us_rate;
            tlv_cfg_pkg::R_MIN_RATE: rd_mux = min_rate;
            tlv_cfg_pkg::R_BURST:    rd_mux = {16'h0, burst};
            default:                 rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rd ? rd_mux : 32'h0;
        end
    end
endmodule : modem_config_tlv_rate_shaper

// ### bench/modem_config_tlv_rate_shaper_sva.sv
// Port-level checks for the setting decoder and upstream shaper
`timescale 1ns/1ns
module shaper_checker (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        cfg_valid,
    input wire logic        tx_req,
    input wire logic        tx_from_cpe,
    input wire logic        tx_mgmt,
    input wire logic        tx_grant,
    input wire logic        tx_block,
    input wire logic [31:0] ds_freq,
    input wire logic        ds_freq_set,
    input wire logic        class_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    block_no_grant_a: assert property (tx_block |-> !tx_grant)
        else $error("blocked frame was granted");
    block_cause_a: assert property (
        tx_block |-> tx_from_cpe && !tx_mgmt)
        else $error("block without a cpe data frame");
    mgmt_pass_a: assert property (
        tx_req && tx_mgmt |-> !tx_block)
        else $error("management frame blocked");
    freq_step_a: assert property (
        ds_freq_set |-> ds_freq % 32'hf424 == 32'h0)
        else $error("stored frequency off the step grid");
    // Values land on the edge that takes the last byte; depth two hits the value byte before it
    freq_cause_a: assert property (
        !$stable(ds_freq) || $rose(ds_freq_set) |-> $past(cfg_valid, 2))
        else $error("frequency changed without setting bytes");
    freq_hold_a: assert property (ds_freq_set |=> ds_freq_set)
        else $error("frequency flag dropped");
    done_pulse_a: assert property (class_done |=> !class_done)
        else $error("class done longer than one cycle");
    done_cause_a: assert property (
        class_done |-> $past(cfg_valid) || $past(cfg_valid, 2))
        else $error("class done without setting bytes");

    grant_seen: cover property (tx_req && tx_grant);
    block_seen: cover property (tx_block);
    done_seen: cover property (class_done);
endmodule : shaper_checker

bind modem_config_tlv_rate_shaper shaper_checker chk (
    .mclk(mclk), .reset(reset), .cfg_valid(cfg_valid), .tx_req(tx_req),
    .tx_from_cpe(tx_from_cpe), .tx_mgmt(tx_mgmt), .tx_grant(tx_grant),
    .tx_block(tx_block), .ds_freq(ds_freq), .ds_freq_set(ds_freq_set),
    .class_done(class_done));

// ### bench/headend_model.sv
// Headend stand-in: sends channel descriptors, polices upstream bytes
`timescale 1ns/1ns
module headend_model #(
    parameter int WINDOW = 100
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ucd_send,
    input  wire logic [7:0]  ucd_id,
    input  wire logic        tx_req,
    input  wire logic        tx_grant,
    input  wire logic [15:0] tx_len,
    input  wire logic [31:0] byte_cap,
    output logic             ucd_valid,
    output logic [7:0]       ucd_chan_id,
    output logic             alarm
);
    int cyc;
    int used;
    always @(posedge mclk) begin
        if (reset) begin
            ucd_valid   <= 1'b0;
            ucd_chan_id <= 8'h5a;
            cyc         <= 0;
            used        <= 0;
            alarm       <= 1'b0;
        end else begin
            ucd_valid   <= ucd_send;
            // Between descriptors the id lines carry a moving pattern
            ucd_chan_id <= ucd_send ? ucd_id : ~ucd_chan_id;
            cyc         <= (cyc == WINDOW - 1) ? 0 : cyc + 1;
            // Every frame is taken whatever the access setting says
            used <= ((cyc == WINDOW - 1) ? 0 : used)
                + ((tx_req && tx_grant) ? int'(tx_len) : 0);
            // Window phase matches the modem's, but a grant in the edge cycle counts here only, so allow double
            if (byte_cap != 32'h0 && used > 2 * int'(byte_cap)) begin
                alarm <= 1'b1;
            end
        end
    end
endmodule : headend_model

// ### bench/tb_modem_config_tlv_rate_shaper.sv
// Self-checking bench for the setting decoder and upstream shaper
`timescale 1ns/1ns
module tb_modem_config_tlv_rate_shaper;
    localparam int WIN = 100;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        cfg_start = 1'b0;
    logic        cfg_valid = 1'b0;
    logic [7:0]  cfg_byte = 8'h0;
    logic        ucd_send = 1'b0;
    logic [7:0]  ucd_id = 8'h0;
    logic        ucd_valid;
    logic [7:0]  ucd_chan_id;
    logic        tx_req = 1'b0;
    logic [15:0] tx_len = 16'h0;
    logic        tx_from_cpe = 1'b0;
    logic        tx_mgmt = 1'b0;
    logic        tx_grant;
    logic        tx_block;
    logic [31:0] ds_freq;
    logic        ds_freq_set;
    logic        class_done;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] cap = 32'h0;
    logic        alarm;
    logic [7:0]  q[$];
    int          error_cnt = 0;
    int          checked = 0;
    int          done_cnt = 0;
    int          cyc = 0;
    // Model: register images by offset/4, status flags apart
    int          mr[10] = '{0: 1, default: 0};
    int          fs = 0, acc = 1, wt = 0, leg = 0, er = 0;

    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (class_done === 1'b1) done_cnt <= done_cnt + 1;
    end

    modem_config_tlv_rate_shaper #(.WINDOW_CYC(WIN)) dut (
        .mclk(mclk), .reset(reset), .cfg_start(cfg_start),
        .cfg_valid(cfg_valid), .cfg_byte(cfg_byte), .ucd_valid(ucd_valid),
        .ucd_chan_id(ucd_chan_id), .tx_req(tx_req), .tx_len(tx_len),
        .tx_from_cpe(tx_from_cpe), .tx_mgmt(tx_mgmt), .tx_grant(tx_grant),
        .tx_block(tx_block), .ds_freq(ds_freq), .ds_freq_set(ds_freq_set),
        .class_done(class_done), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));
    headend_model #(.WINDOW(WIN)) he (
        .mclk(mclk), .reset(reset), .ucd_send(ucd_send), .ucd_id(ucd_id),
        .tx_req(tx_req), .tx_grant(tx_grant), .tx_len(tx_len),
        .byte_cap(cap), .ucd_valid(ucd_valid), .ucd_chan_id(ucd_chan_id),
        .alarm(alarm));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
        @(posedge mclk);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
    endtask : rd_reg

    task automatic chk_regs;
        logic [31:0] v;
        mr[1] = fs * 16 + acc * 8 + wt * 4 + leg * 2 + er;
        for (int i = 0; i < 10; i++) begin
            rd_reg(8'(4 * i), v);
            chk($sformatf("reg %0h", 4 * i), mr[i], v);
        end
        chk("freq pin", mr[2], ds_freq);
        chk("freq set pin", fs, ds_freq_set);
    endtask : chk_regs

    task automatic clear_err;
        wr_reg(tlv_cfg_pkg::R_STATUS, 32'h1);
        er = 0;
    endtask : clear_err

    task automatic put(input logic [7:0] t, input int n,
                       input logic [31:0] v);
        q.push_back(t);
        q.push_back(8'(n));
        for (int i = n - 1; i >= 0; i--) q.push_back(v[8*i +: 8]);
    endtask : put

    task automatic wrap;
        q = {8'h04, 8'(q.size()), q};
    endtask : wrap

    task automatic send;
        foreach (q[i]) begin
            cfg_valid <= 1'b1;
            cfg_byte  <= q[i];
            @(posedge mclk);
        end
        cfg_valid <= 1'b0;
        q.delete();
        repeat (2) @(posedge mclk);
    endtask : send

    task automatic desc(input logic [7:0] i);
        ucd_id   <= i;
        ucd_send <= 1'b1;
        @(posedge mclk);
        ucd_send <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : desc

    // w returns lim when no grant came; blk is the first-cycle block
    task automatic frame(input int len, input logic cpe, input logic mg,
                         input int lim, output int w, output logic blk);
        tx_req      <= 1'b1;
        tx_len      <= 16'(len);
        tx_from_cpe <= cpe;
        tx_mgmt     <= mg;
        w = 0;
        @(negedge mclk);
        blk = tx_block;
        while (tx_grant !== 1'b1 && w < lim) begin
            @(negedge mclk);
            w++;
        end
        @(posedge mclk);
        tx_req <= 1'b0;
        @(posedge mclk);
    endtask : frame

    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        give_verdict;
    end

    initial begin
        int w, k, t0;
        logic b;
        logic [7:0] bt[4] = '{8'h01, 8'h01, 8'h04, 8'h07};
        logic [7:0] bv[4] = '{8'h00, 8'h11, 8'h08, 8'h02};
        k = $urandom(73);
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk_regs;
        // A restart mid-value must drop the partial setting
        q = {8'h01, 8'h04, 8'hff, 8'hff};
        send;
        cfg_start <= 1'b1;
        cfg_valid <= 1'b1;
        @(posedge mclk);
        cfg_start <= 1'b0;
        cfg_valid <= 1'b0;
        @(posedge mclk);
        k = $urandom_range(16000, 1) * 62500;
        put(8'h01, 4, 32'(k));
        send;
        mr[2] = k;
        fs = 1;
        chk_regs;
        put(8'h01, 4, 32'(k + 62500 + 1));
        put(8'h50, 3, $urandom);
        put(8'h03, 2, 32'h1);
        send;
        er = 1;
        chk_regs;
        clear_err;
        k = $urandom_range(255, 2);
        put(8'h02, 1, 32'(k));
        send;
        mr[3] = k;
        wt = 1;
        chk_regs;
        frame(64, 1'b0, 1'b0, 20, w, b);
        chk("held for descriptor", 20, w);
        desc(8'(k ^ 1));
        desc(8'(k));
        wt = 0;
        chk_regs;
        frame(64, 1'b0, 1'b0, 20, w, b);
        chk("descriptor grant", 1, 32'(w < 20));
        put(8'h03, 1, 32'h0);
        send;
        acc = 0;
        frame(64, 1'b1, 1'b0, 10, w, b);
        chk("cpe blocked", 1, 32'(b));
        chk("cpe held", 10, w);
        frame(64, 1'b1, 1'b1, 10, w, b);
        chk("mgmt wait", 0, w);
        frame(64, 1'b0, 1'b0, 10, w, b);
        chk("own wait", 0, w);
        put(8'h03, 1, 32'h2);
        put(8'h03, 1, 32'h1);
        send;
        acc = 1;
        er = 1;
        chk_regs;
        clear_err;
        mr[4] = $urandom_range(1, 0) * 2048 + $urandom_range(7, 0) * 256
            + $urandom_range(16, 1);
        mr[5] = $urandom;
        mr[6] = 2400;
        mr[7] = $urandom;
        mr[8] = 120;
        put(8'h01, 1, 32'(mr[4] % 256));
        put(8'h02, 4, 32'(mr[5]));
        put(8'h03, 4, 32'(mr[6]));
        put(8'h04, 1, 32'(mr[4] / 256 % 8));
        put(8'h05, 4, 32'(mr[7]));
        put(8'h06, 2, 32'(mr[8]));
        put(tlv_cfg_pkg::class_privacy_enable_subtype, 1, 32'(mr[4] / 2048));
        wrap;
        t0 = done_cnt;
        send;
        leg = 1;
        chk("class pulses", t0 + 1, done_cnt);
        chk_regs;
        for (int i = 0; i < 4; i++) begin
            put(bt[i], 1, 32'(bv[i]));
            wrap;
            send;
            er = 1;
            chk_regs;
            clear_err;
        end
        cap <= 32'd300;
        for (int i = 0; i < 7; i++) begin
            frame(100, 1'b0, 1'b0, 300, w, b);
            chk("frame held", 1, 32'(w < 300));
            if (i == 0) t0 = cyc;
        end
        chk("shaped span", 1, 32'(cyc - t0 > WIN));
        chk("policing", 0, alarm);
        frame(130, 1'b0, 1'b0, 150, w, b);
        chk("over burst", 150, w);
        frame(120, 1'b0, 1'b0, 300, w, b);
        chk("burst fit", 1, 32'(w < 300));
        // Seven frames meet one window edge at most, so shaping would hold one
        wr_reg(tlv_cfg_pkg::R_CTRL, 32'h0);
        mr[0] = 0;
        for (int i = 0; i < 7; i++) begin
            frame(100, 1'b0, 1'b0, 5, w, b);
            chk("unshaped wait", 0, w);
        end
        chk_regs;
        give_verdict;
    end
endmodule : tb_modem_config_tlv_rate_shaper
